// ==== logic/phy_aux_led_control.sv ====
// Behaviour
// R1: Loopback bit returns transmit data on receive
// R2: Looped data never reaches the line side
// R3: Status bit 7 mirrors the loopback control
// R4: Reverse bit flips transmit and receive bytes
// R5: Jabber ignored when disabled at 10 Mb/s
// R6: Software writes zero to reserved aux bits
// R7: Traffic LED lights on tx, rx, idle error
// R8: Mode field: normal, off, blink, on
// R9: Only normal mode shows live status
// R10: Link10 LED lights on 10 Mb/s link
// R11: Link100 LED lights on 100 Mb/s link
// R12: Link1000 LED lights on 1000 Mb/s link
// R13: Duplex LED lights on full-duplex link
// R14: All five LED fields share one encoding
// R15: Compact mode repurposes the link10 LED
// R16: Select bit picks link or link-and-traffic
// R17: Link steady; traffic blinks the combined LED
// R18: Fields reset to zero, reserved read zero
// R19: One shared counted blink phase for all
`timescale 1ns/100ps
`default_nettype none

module phy_aux_led_control
   import phy_aux_led_pkg::*;
#(
   parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] mac_txd,
   input wire logic mac_tx_en,
   input wire logic mac_tx_er,
   output logic [7:0] mac_rxd,
   output logic mac_rx_dv,
   output logic mac_rx_er,
   output logic [7:0] line_txd,
   output logic line_tx_en,
   output logic line_tx_er,
   input wire logic [7:0] line_rxd,
   input wire logic line_rx_dv,
   input wire logic line_rx_er,
   input wire logic link10,
   input wire logic link100,
   input wire logic link1000,
   input wire logic full_duplex,
   input wire logic idle_error,
   input wire logic jabber_detect,
   output logic jabber_event,
   output logic [NUM_LEDS-1:0] led_on
);

   localparam int BLINK_W = (BLINK_HALF > 1) ? $clog2(BLINK_HALF) : 1;
   localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF - 1);

   typedef struct packed {
      logic loop_en;
      logic rev_en;
      logic jab_dis;
      logic [15:0] led_ctrl;
      logic compact_sel;
      logic [BLINK_W-1:0] blink_cnt;
      logic blink_phase;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] rdata;
      logic [NUM_LEDS-1:0] led;
      logic [7:0] mrxd;
      logic mrx_dv;
      logic mrx_er;
      logic [7:0] ltxd;
      logic ltx_en;
      logic ltx_er;
      logic jab_out;
   } state_s;

   state_s state_q;
   state_s state_d;
   logic [NUM_LEDS-1:0] led_status;
   logic [NUM_LEDS-1:0] led_next;
   logic link_any;
   logic traffic;
   logic addr_ok;
   logic [7:0] addr_idx;

   // Bit-order reversal within a byte, used on both data directions
   function automatic logic [7:0] flip8(input logic [7:0] x);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = x[7 - i];
      end
      return r;
   endfunction

   // Address decode; upper bits must be zero to hit a register
   assign addr_idx = haddr[9:2];
   assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

   // Live status feeding the LED decoders
   assign link_any = link10 | link100 | link1000;
   assign traffic = mac_tx_en | line_rx_dv | idle_error; // R7

   always_comb begin
      led_status = '0;
      led_status[LED_DUPLEX] = full_duplex & link_any; // R13
      led_status[LED_LINK1000] = link1000; // R12
      led_status[LED_LINK100] = link100; // R11
      led_status[LED_TRAFFIC] = traffic; // R7
      // Compact mode takes over the link10 indicator
      if (state_q.led_ctrl[LED_COMPACT_BIT]) begin // R15
         if (state_q.compact_sel) begin
            led_status[LED_LINK10] = link_any; // R16 R17
         end else begin
            // Dark half of the blink only while there is traffic
            led_status[LED_LINK10] = link_any & ~(traffic & state_q.blink_phase); // R16 R17
         end
      end else begin
         led_status[LED_LINK10] = link10; // R10
      end
   end

   // One identical mode decoder per LED
   for (genvar g = 0; g < NUM_LEDS; g++) begin : g_led
      led_mode_e mode;
      assign mode = led_mode_e'(state_q.led_ctrl[LED_FIELD_BASE + 2 * g +: 2]); // R14
      always_comb begin
         case (mode)
            MODE_NORMAL: led_next[g] = led_status[g]; // R8 R9
            MODE_OFF: led_next[g] = 1'b0; // R8 R9
            MODE_BLINK: led_next[g] = state_q.blink_phase; // R8 R19
            MODE_ON: led_next[g] = 1'b1; // R8 R9
            default: led_next[g] = 1'b0;
         endcase
      end
   end

   // Next-state logic for the whole block
   always_comb begin
      state_d = state_q;
      // Shared blink time base; a single phase keeps all blinking LEDs in step
      if (state_q.blink_cnt >= BLINK_LAST) begin // R19
         state_d.blink_cnt = '0;
         state_d.blink_phase = ~state_q.blink_phase;
      end else begin
         state_d.blink_cnt = state_q.blink_cnt + 1'b1;
      end
      // Write data phase commits here
      if (state_q.wr_pend) begin
         case (state_q.wr_idx)
            AUX_IDX: begin
               state_d.loop_en = hwdata[AUX_LOOP_BIT]; // R18
               state_d.rev_en = hwdata[AUX_REV_BIT]; // R18
               state_d.jab_dis = hwdata[AUX_JAB_BIT]; // R18
            end
            LED_IDX: state_d.led_ctrl = hwdata[15:0]; // R18
            COMPACT_SEL_IDX: state_d.compact_sel = hwdata[COMPACT_SEL_BIT]; // R16
            default: state_d.wr_pend = 1'b0;
         endcase
      end
      state_d.wr_pend = 1'b0;
      // Address phase; reads see any write committing this same cycle
      if (hsel && hready && (htrans == HTRANS_NONSEQ) && addr_ok) begin
         if (hwrite) begin
            // Sub-word writes are dropped rather than merged
            state_d.wr_pend = (hsize == HSIZE_WORD);
            state_d.wr_idx = addr_idx;
         end else begin
            state_d.rdata = 32'h00000000;
            case (addr_idx)
               STATUS_IDX: state_d.rdata[LOOP_STAT_BIT] = state_d.loop_en; // R3
               AUX_IDX: begin
                  state_d.rdata[AUX_LOOP_BIT] = state_d.loop_en;
                  state_d.rdata[AUX_REV_BIT] = state_d.rev_en;
                  state_d.rdata[AUX_JAB_BIT] = state_d.jab_dis; // R18
               end
               LED_IDX: state_d.rdata[15:0] = state_d.led_ctrl;
               COMPACT_SEL_IDX: state_d.rdata[COMPACT_SEL_BIT] = state_d.compact_sel;
               default: state_d.rdata = 32'h00000000;
            endcase
         end
      end else if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite) begin
         state_d.rdata = 32'h00000000;
      end
      // Data path; both directions take one register stage
      if (state_q.loop_en) begin
         // Straight copy, no reversal, nothing to the line
         state_d.mrxd = mac_txd; // R1
         state_d.mrx_dv = mac_tx_en; // R1
         state_d.mrx_er = mac_tx_er; // R1
         state_d.ltxd = 8'h00; // R2
         state_d.ltx_en = 1'b0; // R2
         state_d.ltx_er = 1'b0; // R2
      end else begin
         state_d.mrxd = state_q.rev_en ? flip8(line_rxd) : line_rxd; // R4
         state_d.mrx_dv = line_rx_dv;
         state_d.mrx_er = line_rx_er;
         state_d.ltxd = state_q.rev_en ? flip8(mac_txd) : mac_txd; // R4
         state_d.ltx_en = mac_tx_en;
         state_d.ltx_er = mac_tx_er;
      end
      // Jabber suppression only applies on a 10 Mb/s link
      state_d.jab_out = jabber_detect & ~(state_q.jab_dis & link10); // R5
      state_d.led = led_next;
   end

   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q.loop_en <= AUX_BIT_RESET; // R18
         state_q.rev_en <= AUX_BIT_RESET;
         state_q.jab_dis <= AUX_BIT_RESET;
         state_q.led_ctrl <= LED_RESET; // R18
         state_q.compact_sel <= COMPACT_SEL_RESET;
         state_q.blink_cnt <= '0;
         state_q.blink_phase <= 1'b0;
         state_q.wr_pend <= 1'b0;
         state_q.wr_idx <= 8'h00;
         state_q.rdata <= 32'h00000000;
         state_q.led <= '0;
         state_q.mrxd <= 8'h00;
         state_q.mrx_dv <= 1'b0;
         state_q.mrx_er <= 1'b0;
         state_q.ltxd <= 8'h00;
         state_q.ltx_en <= 1'b0;
         state_q.ltx_er <= 1'b0;
         state_q.jab_out <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = state_q.rdata;
   assign mac_rxd = state_q.mrxd;
   assign mac_rx_dv = state_q.mrx_dv;
   assign mac_rx_er = state_q.mrx_er;
   assign line_txd = state_q.ltxd;
   assign line_tx_en = state_q.ltx_en;
   assign line_tx_er = state_q.ltx_er;
   assign jabber_event = state_q.jab_out;
   assign led_on = state_q.led;

   // Checks on the block's own outputs
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_loop_return: assert property ( // R1
      state_q.loop_en |=> (mac_rxd == $past(mac_txd)) && (mac_rx_dv == $past(mac_tx_en)))
      else $error("loopback did not return transmit data");

   a_loop_bypass: assert property ( // R2
      state_q.loop_en |=> !line_tx_en && !line_tx_er && (line_txd == 8'h00))
      else $error("looped data reached the line side");

   a_status_mirror: assert property ( // R3
      (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && addr_ok
         && addr_idx == STATUS_IDX && !state_q.wr_pend)
      |=> hrdata[LOOP_STAT_BIT] == $past(state_q.loop_en))
      else $error("status bit does not mirror loopback");

   a_reverse_tx: assert property ( // R4
      (!state_q.loop_en && state_q.rev_en) |=> line_txd == flip8($past(mac_txd)))
      else $error("transmit byte not reversed");

   a_normal_rx: assert property ( // R4
      (!state_q.loop_en && !state_q.rev_en) |=> mac_rxd == $past(line_rxd))
      else $error("receive byte altered in normal order");

   a_jabber_mask: assert property ( // R5
      (state_q.jab_dis && link10) |=> !jabber_event)
      else $error("jabber reported while disabled");

   a_jabber_pass: assert property ( // R5
      (jabber_detect && !state_q.jab_dis) |=> jabber_event)
      else $error("jabber lost while enabled");

   a_traffic_led: assert property ( // R7
      (state_q.led_ctrl[15:14] == MODE_NORMAL && mac_tx_en) |=> led_on[LED_TRAFFIC])
      else $error("traffic LED dark during transmit");

   a_forced_modes: assert property ( // R9
      (state_q.led_ctrl[9:8] == MODE_OFF) ##1 (state_q.led_ctrl[9:8] == MODE_OFF)
      |-> !led_on[LED_LINK1000])
      else $error("forced-off LED lit");

   a_link100_led: assert property ( // R11
      (state_q.led_ctrl[11:10] == MODE_NORMAL) |=> led_on[LED_LINK100] == $past(link100))
      else $error("link100 LED does not follow link");

   a_blink_shared: assert property ( // R19
      (state_q.led_ctrl[15:14] == MODE_BLINK && state_q.led_ctrl[7:6] == MODE_BLINK)
      |=> led_on[LED_TRAFFIC] == led_on[LED_DUPLEX])
      else $error("blinking LEDs out of phase");

   a_compact_link: assert property ( // R17
      (state_q.led_ctrl[LED_COMPACT_BIT] && state_q.compact_sel
         && state_q.led_ctrl[13:12] == MODE_NORMAL && link_any)
      |=> led_on[LED_LINK10])
      else $error("compact link LED not steady");

   // Data path checks on the reversed receive byte and on the strobes
   a_reverse_rx: assert property ( // R4
      (!state_q.loop_en && state_q.rev_en) |=> mac_rxd == flip8($past(line_rxd)))
      else $error("receive byte not reversed");

   a_loop_error: assert property ( // R1
      state_q.loop_en |=> mac_rx_er == $past(mac_tx_er))
      else $error("loopback lost the error flag");

   a_line_forward: assert property ( // R2
      !state_q.loop_en
      |=> (line_tx_en == $past(mac_tx_en)) && (line_tx_er == $past(mac_tx_er)))
      else $error("transmit strobes not forwarded to the line");

   // LED decoders in normal, forced and blink modes
   a_link10_led: assert property ( // R10
      (state_q.led_ctrl[13:12] == MODE_NORMAL && !state_q.led_ctrl[LED_COMPACT_BIT])
      |=> led_on[LED_LINK10] == $past(link10))
      else $error("link10 LED does not follow link");

   a_link1000_led: assert property ( // R12
      (state_q.led_ctrl[9:8] == MODE_NORMAL) |=> led_on[LED_LINK1000] == $past(link1000))
      else $error("link1000 LED does not follow link");

   a_duplex_led: assert property ( // R13
      (state_q.led_ctrl[7:6] == MODE_NORMAL)
      |=> led_on[LED_DUPLEX] == $past(full_duplex && link_any))
      else $error("duplex LED does not follow full-duplex link");

   a_forced_on: assert property ( // R8
      (state_q.led_ctrl[15:14] == MODE_ON) |=> led_on[LED_TRAFFIC])
      else $error("forced-on LED dark");

   a_blink_follow: assert property ( // R19
      (state_q.led_ctrl[11:10] == MODE_BLINK)
      |=> led_on[LED_LINK100] == $past(state_q.blink_phase))
      else $error("blinking LED off the shared phase");

   // Phase may only turn over when the counter wraps
   a_blink_period: assert property ( // R19
      $changed(state_q.blink_phase) |-> $past(state_q.blink_cnt) == BLINK_LAST)
      else $error("blink phase turned early");

   a_compact_dark: assert property ( // R17
      (state_q.led_ctrl[LED_COMPACT_BIT] && !state_q.compact_sel
         && state_q.led_ctrl[13:12] == MODE_NORMAL && traffic && state_q.blink_phase)
      |=> !led_on[LED_LINK10])
      else $error("compact LED not blinking with traffic");

   a_compact_nolink: assert property ( // R16
      (state_q.led_ctrl[LED_COMPACT_BIT] && state_q.led_ctrl[13:12] == MODE_NORMAL
         && !link_any)
      |=> !led_on[LED_LINK10])
      else $error("compact LED lit without link");

   // The LED readback check skips the cycle in which a write commits
   a_led_readback: assert property ( // R18
      (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && addr_ok
         && addr_idx == LED_IDX && !state_q.wr_pend)
      |=> hrdata == {16'h0000, $past(state_q.led_ctrl)})
      else $error("LED register readback wrong");

   a_aux_reserved: assert property ( // R18
      (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && addr_ok
         && addr_idx == AUX_IDX)
      |=> (hrdata[31:6] == 26'h0000000) && (hrdata[3:1] == 3'h0))
      else $error("reserved auxiliary bits read nonzero");

   c_loopback: cover property (state_q.loop_en && mac_tx_en);
   c_reverse: cover property (state_q.rev_en && !state_q.loop_en && mac_tx_en);
   c_blink_toggle: cover property ($rose(state_q.blink_phase));
   c_compact_traffic: cover property (state_q.led_ctrl[LED_COMPACT_BIT] && link_any && traffic);
   c_forced_on: cover property (state_q.led_ctrl[15:14] == MODE_ON);

endmodule // phy_aux_led_control

`default_nettype wire

// ==== logic/phy_aux_led_pkg.sv ====
package phy_aux_led_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] STATUS_IDX = 8'h11;
   localparam logic [7:0] AUX_IDX = 8'h12;
   localparam logic [7:0] LED_IDX = 8'h13;
   localparam logic [7:0] COMPACT_SEL_IDX = 8'h1A;

   // Field positions
   localparam int LOOP_STAT_BIT = 7;
   localparam int AUX_LOOP_BIT = 5;
   localparam int AUX_REV_BIT = 4;
   localparam int AUX_JAB_BIT = 0;
   localparam int LED_FIELD_BASE = 6;
   localparam int LED_COMPACT_BIT = 5;
   localparam int COMPACT_SEL_BIT = 0;

   // LED order inside the mode field block, lowest field first
   localparam int NUM_LEDS = 5;
   localparam int LED_DUPLEX = 0;
   localparam int LED_LINK1000 = 1;
   localparam int LED_LINK100 = 2;
   localparam int LED_LINK10 = 3;
   localparam int LED_TRAFFIC = 4;

   // Reset values
   localparam logic AUX_BIT_RESET = 1'b0;
   localparam logic [15:0] LED_RESET = 16'h0000;
   localparam logic COMPACT_SEL_RESET = 1'b0;

   // Timing
   localparam int CLK_KHZ = 20000;
   localparam int BLINK_PERIOD_MS = 750;
   localparam int BLINK_HALF_CYCLES = BLINK_PERIOD_MS * CLK_KHZ / 2;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'h0;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_OFF = 2'b01,
      MODE_BLINK = 2'b10,
      MODE_ON = 2'b11
   } led_mode_e;

endpackage

// ==== verification/led_bank_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module led_bank_model
   import phy_aux_led_pkg::*;
(
   input wire logic hclk,
   input wire logic [NUM_LEDS-1:0] led_on,
   output logic [NUM_LEDS-1:0] lit,
   output logic [15:0] changes
);
   logic [NUM_LEDS-1:0] last_q = '0;
   logic [15:0] count_q = 16'h0000;

   // Lamps follow their drivers with no delay of their own
   assign lit = led_on;

   // Count visible changes so that a blink rate can be judged
   assign changes = count_q;
   always @(posedge hclk) begin
      last_q <= led_on;
      if (last_q !== led_on) begin
         count_q <= count_q + 16'h0001;
      end
   end
endmodule // led_bank_model

`default_nettype wire

// ==== verification/phy_aux_led_control_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module phy_aux_led_control_tb;
   import phy_aux_led_pkg::*;
   // Short blink half period keeps the run brief
   localparam int HALF = 8;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = HSIZE_WORD;
   logic hready, hreadyout, hresp, mac_rx_dv, mac_rx_er, line_tx_en, line_tx_er, jabber_event;
   logic [7:0] mac_txd = 8'h00, line_rxd = 8'h00, mac_rxd, line_txd;
   logic mac_tx_en = 1'b0, mac_tx_er = 1'b0, line_rx_dv = 1'b0, line_rx_er = 1'b0;
   logic link10 = 1'b0, link100 = 1'b0, link1000 = 1'b0, full_duplex = 1'b0;
   logic idle_error = 1'b0, jabber_detect = 1'b0;
   logic [NUM_LEDS-1:0] led_on, lit;
   logic [15:0] changes;
   int fail_count = 0, num_checks = 0, cycles = 0;

   assign hready = hreadyout;
   always #25 hclk = ~hclk;

   phy_aux_led_control #(.BLINK_HALF(HALF)) u_phy_aux_led_control (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .mac_tx_er(mac_tx_er),
      .mac_rxd(mac_rxd), .mac_rx_dv(mac_rx_dv), .mac_rx_er(mac_rx_er), .line_txd(line_txd),
      .line_tx_en(line_tx_en), .line_tx_er(line_tx_er), .line_rxd(line_rxd),
      .line_rx_dv(line_rx_dv), .line_rx_er(line_rx_er), .link10(link10), .link100(link100),
      .link1000(link1000), .full_duplex(full_duplex), .idle_error(idle_error),
      .jabber_detect(jabber_detect), .jabber_event(jabber_event), .led_on(led_on));

   led_bank_model u_led_bank_model (.hclk(hclk), .led_on(led_on), .lit(lit), .changes(changes));

   task automatic finish_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the expected run length
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tk(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Single transfer at the current hsize; no wait count assumed, hready decides each phase
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0);
      chk(what, exp, rd);
      chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
   endtask

   task automatic stat(input logic [5:0] s);
      {link10, link100, link1000, full_duplex, idle_error, mac_tx_en} <= s;
   endtask

   task automatic t_regs();
      rdchk("aux reset", AUX_IDX, 32'h0);
      rdchk("led reset", LED_IDX, 32'h0);
      rdchk("sel reset", COMPACT_SEL_IDX, 32'h0);
      rdchk("unmapped", 8'h20, 32'h0);
      bus(1'b1, AUX_IDX, 32'h31);
      rdchk("aux rw", AUX_IDX, 32'h31);
      bus(1'b1, LED_IDX, 32'hFFFF);
      rdchk("led rw", LED_IDX, 32'hFFFF);
      // Sub-word writes must leave the register alone
      hsize <= 3'h0;
      bus(1'b1, LED_IDX, 32'h0);
      hsize <= HSIZE_WORD;
      rdchk("byte write", LED_IDX, 32'hFFFF);
      bus(1'b1, COMPACT_SEL_IDX, 32'h1);
      rdchk("sel rw", COMPACT_SEL_IDX, 32'h1);
   endtask

   // Loopback must echo transmit data and keep the line quiet
   task automatic t_loop();
      bus(1'b1, AUX_IDX, 32'h20);
      rdchk("loop status", STATUS_IDX, 32'h80);
      mac_txd <= 8'hA5;
      mac_tx_en <= 1'b1;
      mac_tx_er <= 1'b1;
      tk(2);
      chk("loop rxd", 32'hA5, {24'h0, mac_rxd});
      chk("loop rx_dv", 32'h1, {31'h0, mac_rx_dv});
      chk("loop rx_er", 32'h1, {31'h0, mac_rx_er});
      chk("loop line en", 32'h0, {31'h0, line_tx_en});
      chk("loop line er", 32'h0, {31'h0, line_tx_er});
      chk("loop line txd", 32'h0, {24'h0, line_txd});
      bus(1'b1, AUX_IDX, 32'h10);
      rdchk("loop off", STATUS_IDX, 32'h0);
      mac_txd <= 8'h01;
      mac_tx_er <= 1'b0;
      line_rxd <= 8'h03;
      tk(2);
      chk("rev txd", 32'h80, {24'h0, line_txd});
      chk("rev rxd", 32'hC0, {24'h0, mac_rxd});
      bus(1'b1, AUX_IDX, 32'h0);
      tk(2);
      chk("fwd txd", 32'h01, {24'h0, line_txd});
      chk("fwd rxd", 32'h03, {24'h0, mac_rxd});
      chk("fwd line en", 32'h1, {31'h0, line_tx_en});
   endtask

   task automatic t_jab();
      bus(1'b1, AUX_IDX, 32'h1);
      stat(6'b100000);
      jabber_detect <= 1'b1;
      tk(2);
      chk("jab off 10M", 32'h0, {31'h0, jabber_event});
      stat(6'b010000);
      tk(2);
      chk("jab 100M", 32'h1, {31'h0, jabber_event});
      bus(1'b1, AUX_IDX, 32'h0);
      stat(6'b100000);
      tk(2);
      chk("jab on 10M", 32'h1, {31'h0, jabber_event});
      jabber_detect <= 1'b0;
   endtask

   // Live status per LED in normal mode
   task automatic t_norm();
      logic [5:0] s[6] = '{6'h20, 6'h10, 6'h0C, 6'h04, 6'h02, 6'h01};
      logic [4:0] e[6] = '{5'h08, 5'h04, 5'h03, 5'h00, 5'h10, 5'h10};
      bus(1'b1, LED_IDX, 32'h0);
      foreach (s[i]) begin
         stat(s[i]);
         tk(2);
         chk("normal led", {27'h0, e[i]}, {27'h0, lit});
      end
      // Receive activity alone must light the traffic LED
      stat(6'h00);
      line_rx_dv <= 1'b1;
      line_rx_er <= 1'b1;
      tk(2);
      chk("rx traffic led", 32'h10, {27'h0, lit});
      chk("rx dv", 32'h1, {31'h0, mac_rx_dv});
      chk("rx er", 32'h1, {31'h0, mac_rx_er});
      line_rx_dv <= 1'b0;
      line_rx_er <= 1'b0;
   endtask

   task automatic t_force();
      led_mode_e m[2] = '{MODE_OFF, MODE_ON};
      foreach (m[i]) begin
         bus(1'b1, LED_IDX, {16'h0, {5{m[i]}}, 6'h0});
         for (int k = 0; k < 2; k++) begin
            stat(k[0] ? 6'h3F : 6'h00);
            tk(2);
            chk("forced led", (m[i] == MODE_ON) ? 32'h1F : 32'h0, {27'h0, lit});
         end
      end
   endtask

   // All blinking LEDs share one phase of period two halves
   task automatic t_blink();
      logic [15:0] c0;
      bus(1'b1, LED_IDX, {16'h0, {5{MODE_BLINK}}, 6'h0});
      tk(2);
      c0 = changes;
      repeat (40) begin
         @(posedge hclk);
         chk("blink phase", 32'h1, {31'h0, (lit === 5'h00) || (lit === 5'h1F)});
      end
      chk("blink rate", 32'h1, {31'h0, (changes - c0) inside {[4:5]}});
   endtask

   task automatic t_compact();
      int lows;
      lows = 0;
      bus(1'b1, LED_IDX, 32'h20);
      bus(1'b1, COMPACT_SEL_IDX, 32'h1);
      stat(6'b010000);
      tk(2);
      chk("compact link", 32'h1, {31'h0, lit[LED_LINK10]});
      bus(1'b1, COMPACT_SEL_IDX, 32'h0);
      stat(6'b010010);
      tk(2);
      repeat (32) begin
         @(posedge hclk);
         lows += (lit[LED_LINK10] === 1'b0) ? 1 : 0;
      end
      chk("compact blink", 32'd16, lows);
      stat(6'b001000);
      tk(2);
      chk("compact steady", 32'h1, {31'h0, lit[LED_LINK10]});
      stat(6'b000000);
      tk(2);
      chk("compact nolink", 32'h0, {31'h0, lit[LED_LINK10]});
   endtask

   initial begin
      tk(5);
      hresetn <= 1'b1;
      t_regs();
      t_loop();
      t_jab();
      t_norm();
      t_force();
      t_blink();
      t_compact();
      finish_test();
   end
endmodule // phy_aux_led_control_tb

`default_nettype wire
